// >>> testbench/rsm_rx_model.sv
// Purpose: receiver front end model that makes the bit clock pin
// Assumes: bit period 125 ns, unrelated in phase to the system clock
// Notes: the clock stands low between frames; bits_o counts bit edges
`timescale 1ns/1ps
`default_nettype none
module rsm_rx_model (
	input wire logic run_i, // frame active
	output logic bit_clk_o, // bit clock pin
	output int bits_o // rising bit edges so far
);
	// a half period of 62.5 ns puts every fourth toggle on the 10 ns grid
	initial begin
		bit_clk_o = 1'b0;
		bits_o = 0;
		forever begin
			#62.5;
			// finish a high phase even when the frame ends, never a runt pulse
			if (run_i || bit_clk_o) begin
				bit_clk_o = ~bit_clk_o;
				bits_o = bits_o + 32'(bit_clk_o);
			end
		end
	end
endmodule : rsm_rx_model
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: self-checking bench of the receive level monitor
// Assumes: 100 MHz clock, bit clock from the front end model
// Notes: random levels come from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rsm_pkg::*;
	logic clk, nrst, run, cca, ccal, jmp, rst_rx, bclk, seen;
	logic [7:0] lvl, rdata, lev, lat, v, l1, old;
	logic [31:0] seed;
	rsm_evt_s evt;
	rsm_bus_s bus;
	int bits, fails, compares;
	logic [7:0] nl [4] = '{8'h50, 8'h61, 8'h20, 8'h00}; // jump steps from 8'h40
	logic [7:0] cl [4] = '{8'h28, 8'h28, 8'h28, 8'h30}; // control per step
	rsm_rx_model u_fe (.run_i(run), .bit_clk_o(bclk), .bits_o(bits));
	rsm_monitor DUT (.sys_clk_i(clk), .nrst_i(nrst), .ce_i(1'b1), .bit_clk_i(bclk),
		.level_i(lvl), .evt_i(evt), .bus_i(bus), .rdata_o(rdata), .level_o(lev),
		.latched_o(lat), .cca_o(cca), .cca_latched_o(ccal), .jump_o(jmp),
		.rx_restart_o(rst_rx));
	// compare and count; outputs are sampled before the edge lands
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// each strobe task leaves one idle edge so no signal is set twice at once
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		// read data stand only in the cycle after the strobe; look once settled
		#1;
		d = rdata;
		@(posedge clk);
	endtask : rd
	task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
		rd(a, v);
		chk(v, e);
	endtask : rdchk
	task automatic evp(input rsm_evt_s e);
		evt <= e;
		@(posedge clk);
		evt <= '0;
		@(posedge clk);
	endtask : evp
	// n bit edges, then room for the pin synchroniser
	task automatic waitb(input int n);
		int s;
		s = bits;
		while (bits - s < n) @(posedge clk);
		repeat (8) @(posedge clk);
	endtask : waitb
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	function automatic logic over(input logic [7:0] a, input logic [7:0] t);
		return a > t;
	endfunction : over
	function automatic logic jumps(input logic [7:0] o, n, t, input logic up, dn);
		return (up && n > o && n - o > t) || (dn && o > n && o - n > t);
	endfunction : jumps
	task automatic finish_test;
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// watchdog, several times the expected run
	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		finish_test;
	end
	initial begin
		nrst = 1'b0;
		run = 1'b0;
		lvl = 8'h00;
		evt = '0;
		bus = '0;
		seed = 32'h74c4;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rdchk(REG_CTRL, CTRL_RST);
		rdchk(REG_LBITS, LBITS_RST);
		rdchk(REG_THR, THR_RST);
		rdchk(REG_OFF, OFF_RST);
		rdchk(REG_JTHR, JTHR_RST);
		rdchk(REG_JWIN, 8'(JWIN_RST));
		rdchk(4'hf, 8'h00);
		// latch after a bit count, asked below the floor
		seed = xs(seed);
		l1 = seed[7:0] | 8'h01;
		lvl <= l1;
		wr(REG_LBITS, 8'h02);
		rdchk(REG_LBITS, MIN_BITS);
		wr(REG_CTRL, 8'(LM_BITS));
		run <= 1'b1;
		waitb(2);
		evp(3'b100);
		chk(lat, 8'h00);
		waitb(2);
		rdchk(REG_FRR, 8'h00);
		waitb(6);
		rdchk(REG_FRR, l1);
		lvl <= l1 ^ 8'h80;
		waitb(3);
		chk(lev, l1 ^ 8'h80);
		chk(lat, l1);
		run <= 1'b0;
		repeat (30) @(posedge clk);
		chk(lat, l1);
		// status query snapshot and its turnaround
		wr(REG_QRY, 8'h00);
		repeat (3280) @(posedge clk);
		rd(REG_STAT, v);
		chk(8'(v[ST_QDONE]), 8'h00);
		repeat (40) @(posedge clk);
		rd(REG_STAT, v);
		chk(8'(v[ST_QDONE]), 8'h01);
		rdchk(REG_QCUR, l1 ^ 8'h80);
		rdchk(REG_QLAT, l1);
		// preamble, sync and averaged bit count latch events
		for (int m = 0; m < 3; m++) begin
			wr(REG_CTRL, m == 2 ? 8'h06 : 8'(m));
			run <= 1'b1;
			evp(3'b100);
			chk(lat, 8'h00);
			waitb(5);
			chk(lat, 8'h00);
			if (m < 2)
				evp(m == 0 ? 3'b010 : 3'b001);
			waitb(4);
			chk(lat, l1 ^ 8'h80);
			run <= 1'b0;
		end
		// threshold at its boundary with a random level; per-bit level, no latch event
		wr(REG_CTRL, 8'(LM_NONE));
		run <= 1'b1;
		seed = xs(seed);
		l1 = seed[7:0] | 8'h01;
		lvl <= l1;
		evp(3'b100);
		waitb(2);
		wr(REG_THR, l1);
		repeat (3) @(posedge clk);
		chk(8'(cca), 8'(over(l1, l1)));
		chk(8'(ccal), 8'h00);
		wr(REG_THR, l1 - 8'h01);
		repeat (3) @(posedge clk);
		chk(8'(cca), 8'(over(l1, l1 - 8'h01)));
		wr(REG_THR, 8'hff);
		repeat (3) @(posedge clk);
		chk(8'(ccal), 8'h01);
		chk(8'(cca), 8'h00);
		// jump steps, enabled only once the frame is under way
		wr(REG_JWIN, 8'h01);
		wr(REG_JTHR, 8'h10);
		lvl <= 8'h40;
		waitb(3);
		for (int k = 0; k < 4; k++) begin
			wr(REG_CTRL, cl[k]);
			wr(REG_STAT, 8'h08);
			old = lvl;
			lvl <= nl[k];
			seen = 1'b0;
			repeat (200) begin
				@(posedge clk);
				seen = seen | rst_rx;
			end
			chk(8'(jmp), 8'(jumps(old, nl[k], 8'h10, cl[k][3], cl[k][4])));
			chk(8'(seen), 8'(jumps(old, nl[k], 8'h10, cl[k][3], cl[k][4])));
		end
		run <= 1'b0;
		finish_test;
	end
endmodule : testbench
`default_nettype wire

// >>> verilog/rsm_monitor.sv
// Purpose: receive signal level monitor with latch, threshold and jump detection
// Assumes: level_i is the post channel filter level; bit clock comes from a pin
// Notes: all state sits in one struct, one comb fill and one register stage
//
// Functional notes
// - measure level only after channel filter
// - fast read returns latched level
// - latch level once per packet
// - query returns latched and current level
// - query done about 33 us later
// - latch on preamble, sync or bits
// - per-bit or four-bit averaged level
// - averaging: latch no earlier than seven bits
// - clear latch at rx start, keep after
// - uncaptured latched level reads zero
// - notify when level above threshold
// - latched and unlatched threshold outputs
// - jump up and down separately enabled
// - jump sets flag, uses jump threshold
// - optional receive restart on jump
// - jump compares across programmable window
// - one level step is half dB
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rsm_monitor #(
	parameter int HIST = 8 // history depth in levels; the deepest jump window reached is 7
) (
	input wire logic sys_clk_i, // system clock
	input wire logic nrst_i, // async reset, active low
	input wire logic ce_i, // clock enable
	input wire logic bit_clk_i, // receiver bit clock pin
	input wire logic [7:0] level_i, // filtered channel level
	input wire rsm_pkg::rsm_evt_s evt_i, // receive chain events
	input wire rsm_pkg::rsm_bus_s bus_i, // register port
	output logic [7:0] rdata_o, // read data, cycle after strobe
	output logic [7:0] level_o, // current level
	output logic [7:0] latched_o, // latched level
	output logic cca_o, // unlatched threshold
	output logic cca_latched_o, // latched threshold
	output logic jump_o, // jump flag
	output logic rx_restart_o // one-cycle restart request
);
	import rsm_pkg::*;

	// whole block state
	typedef struct packed {
		logic [2:0] bsync; // bit clock synchroniser
		logic bstab; // agreed bit clock level
		logic [7:0] ctrl;
		logic [7:0] lbits;
		logic [7:0] thr;
		logic [7:0] off; // stored for the host only
		logic [7:0] jthr;
		logic [2:0] jwin;
		logic [7:0] cur; // current level
		logic [7:0] lat; // latched level
		logic latv; // latch captured
		logic pend; // latch event seen
		logic [7:0] bitcnt; // bits since rx start
		logic [9:0] acc; // averaging sum
		logic [1:0] avgn; // samples in sum
		logic [HIST-1:0][7:0] hist; // past levels, newest first
		logic cca;
		logic ccal;
		logic jflag;
		logic rst;
		logic qbusy;
		logic qdone;
		logic [11:0] qcnt;
		logic [7:0] qcur;
		logic [7:0] qlat;
		logic [7:0] rdata;
	} rsm_state_s;

	rsm_state_s s_q, s_d; // registered state and next value
	logic tick; // one cycle per bit
	logic [7:0] minb; // least latch time
	logic [7:0] old; // level one window earlier
	logic [2:0] widx; // window index

	// bit tick on rising edge of the agreed bit clock
	assign tick = (s_q.bsync[1] == s_q.bsync[2]) && s_q.bsync[2] && !s_q.bstab;
	// averaging needs a longer settle before latching
	assign minb = s_q.ctrl[CTL_AVG] ? MIN_BITS_AVG : MIN_BITS;
	assign widx = (s_q.jwin == 3'h0) ? 3'h0 : 3'(s_q.jwin - 3'h1);
	assign old = s_q.hist[widx];

	// next state
	always_comb begin
		logic [9:0] sum;
		logic [7:0] nl;
		logic nv;
		logic up;
		logic dn;
		logic jset; // jump event in this cycle
		sum = 10'h000;
		jset = 1'b0;
		nl = 8'h00;
		nv = 1'b0;
		up = 1'b0;
		dn = 1'b0;
		s_d = s_q;
		s_d.rst = 1'b0;
		// first stage feeds only the second
		s_d.bsync = {s_q.bsync[1:0], bit_clk_i};
		if (s_q.bsync[1] == s_q.bsync[2]) begin
			s_d.bstab = s_q.bsync[2];
		end
		// level sampled per bit after the channel filter
		if (tick) begin
			sum = s_q.acc + {2'b00, level_i};
			if (s_q.ctrl[CTL_AVG]) begin
				// four-bit mean updated once per four bits
				s_d.acc = sum;
				s_d.avgn = s_q.avgn + 2'h1;
				if (s_q.avgn == 2'h3) begin
					nl = sum[9:2];
					nv = 1'b1;
					s_d.acc = 10'h000;
				end
			end else begin
				nl = level_i;
				nv = 1'b1;
				s_d.acc = 10'h000;
				s_d.avgn = 2'h0;
			end
			if (s_q.bitcnt != 8'hff) begin
				s_d.bitcnt = s_q.bitcnt + 8'h01;
			end
		end
		// new level: jump check against the window, then history shift
		if (nv) begin
			s_d.cur = nl;
			up = (nl > old) && (8'(nl - old) > s_q.jthr);
			dn = (old > nl) && (8'(old - nl) > s_q.jthr);
			if ((up && s_q.ctrl[CTL_JUP]) || (dn && s_q.ctrl[CTL_JDN])) begin
				s_d.jflag = 1'b1;
				jset = 1'b1;
				s_d.rst = s_q.ctrl[CTL_JRST];
			end
			for (int i = HIST - 1; i > 0; i--) begin
				s_d.hist[i] = s_q.hist[i-1];
			end
			s_d.hist[0] = nl;
		end
		// threshold: unsigned compare of current level
		s_d.cca = s_q.cur > s_q.thr;
		if (s_q.cca) begin
			s_d.ccal = 1'b1;
		end
		// latch event selection
		unique case (rsm_mode_e'(s_q.ctrl[1:0]))
			LM_PREAMBLE: begin
				if (evt_i.preamble) s_d.pend = 1'b1;
			end
			LM_SYNC: begin
				if (evt_i.sync) s_d.pend = 1'b1;
			end
			LM_BITS: begin
				if (s_q.bitcnt >= s_q.lbits) s_d.pend = 1'b1;
			end
			LM_NONE: begin
				s_d.pend = s_q.pend;
			end
		endcase
		// capture once, never before the least settle time
		if (s_q.pend && !s_q.latv && s_q.bitcnt >= minb) begin
			s_d.lat = s_q.cur;
			s_d.latv = 1'b1;
		end
		// query turnaround counter
		if (s_q.qbusy) begin
			s_d.qcnt = s_q.qcnt + 12'h001;
			if (s_q.qcnt == QRY_LAST) begin
				s_d.qbusy = 1'b0;
				s_d.qdone = 1'b1;
			end
		end
		// register writes
		if (bus_i.wr) begin
			unique case (bus_i.addr)
				REG_CTRL: s_d.ctrl = bus_i.wdata;
				REG_LBITS: s_d.lbits = (bus_i.wdata < MIN_BITS) ? MIN_BITS : bus_i.wdata;
				REG_THR: s_d.thr = bus_i.wdata;
				REG_OFF: s_d.off = bus_i.wdata;
				REG_JTHR: s_d.jthr = bus_i.wdata;
				REG_JWIN: s_d.jwin = bus_i.wdata[2:0];
				REG_QRY: begin
					// snapshot at the moment the query is taken
					s_d.qcur = s_q.cur;
					s_d.qlat = s_q.lat;
					s_d.qbusy = 1'b1;
					s_d.qdone = 1'b0;
					s_d.qcnt = 12'h000;
				end
				REG_STAT: begin
					// write one clears, a new set in the same cycle wins
					// a flag already up that is hit again must stay up
					if (bus_i.wdata[ST_JMP] && !jset) s_d.jflag = 1'b0;
					if (bus_i.wdata[ST_CCAL] && !s_q.cca) s_d.ccal = 1'b0;
				end
				default: s_d.rdata = s_d.rdata;
			endcase
		end
		// receive start clears the latch and restarts timing
		if (evt_i.rx_start) begin
			s_d.lat = 8'h00;
			s_d.latv = 1'b0;
			s_d.pend = 1'b0;
			s_d.bitcnt = 8'h00;
			s_d.acc = 10'h000;
			s_d.avgn = 2'h0;
			s_d.ccal = 1'b0;
		end
		// read data stands only in the cycle after the strobe
		s_d.rdata = 8'h00;
		if (bus_i.rd) begin
			unique case (bus_i.addr)
				REG_CTRL: s_d.rdata = s_q.ctrl;
				REG_LBITS: s_d.rdata = s_q.lbits;
				REG_THR: s_d.rdata = s_q.thr;
				REG_OFF: s_d.rdata = s_q.off;
				REG_JTHR: s_d.rdata = s_q.jthr;
				REG_JWIN: s_d.rdata = {5'h00, s_q.jwin};
				REG_FRR: s_d.rdata = s_q.lat;
				REG_QCUR: s_d.rdata = s_q.qcur;
				REG_QLAT: s_d.rdata = s_q.qlat;
				REG_STAT: s_d.rdata = {3'h0, s_q.qdone, s_q.jflag, s_q.ccal, s_q.cca, s_q.latv};
				default: s_d.rdata = 8'h00;
			endcase
		end
	end

	// single register stage, frozen while ce_i is low
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q <= '0;
			s_q.ctrl <= CTRL_RST;
			s_q.lbits <= LBITS_RST;
			s_q.thr <= THR_RST;
			s_q.off <= OFF_RST;
			s_q.jthr <= JTHR_RST;
			s_q.jwin <= JWIN_RST;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rdata;
	assign level_o = s_q.cur;
	assign latched_o = s_q.lat;
	assign cca_o = s_q.cca;
	assign cca_latched_o = s_q.ccal;
	assign jump_o = s_q.jflag;
	assign rx_restart_o = s_q.rst;

	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_query_start;
		ce_i && bus_i.wr && bus_i.addr == REG_QRY;
	endsequence
	sequence s_fast_read;
		ce_i && bus_i.rd && bus_i.addr == REG_FRR;
	endsequence

	a_latch_clear: assert property (ce_i && evt_i.rx_start |=> !s_q.latv && latched_o == 8'h00)
		else $error("latch not cleared at rx start");
	a_latch_zero: assert property (!s_q.latv |-> latched_o == 8'h00)
		else $error("uncaptured latch not zero");
	a_latch_once: assert property (s_q.latv && !evt_i.rx_start |=> s_q.latv && $stable(latched_o))
		else $error("latched level changed within packet");
	a_avg_min: assert property ($rose(s_q.latv) && s_q.ctrl[CTL_AVG] |-> s_q.bitcnt >= MIN_BITS_AVG)
		else $error("averaged latch before seven bits");
	a_latch_min: assert property ($rose(s_q.latv) |-> s_q.bitcnt >= MIN_BITS)
		else $error("latch before four bits");
	a_fast_read: assert property (s_fast_read |=> rdata_o == $past(latched_o))
		else $error("fast read not latched level");
	a_query_time: assert property ($rose(s_q.qdone) |-> $past(s_q.qcnt) == QRY_LAST)
		else $error("query done at wrong time");
	a_query_snap: assert property (s_query_start ##1 ce_i[*2] |-> s_q.qcur == $past(level_o, 2))
		else $error("query current level not captured");
	a_cca_latch: assert property (ce_i && cca_o && !evt_i.rx_start |=> cca_latched_o)
		else $error("threshold latch missed");
	a_jump_restart: assert property (rx_restart_o |-> jump_o && s_q.ctrl[CTL_JRST])
		else $error("restart without jump");
endmodule : rsm_monitor
`default_nettype wire

// >>> verilog/rsm_pkg.sv
// Purpose: shared constants and carriers of the receive level monitor
// Assumes: 8-bit register port, 100 MHz system clock
// Notes: register indexes are word indexes on the plain port
`default_nettype none
package rsm_pkg;
	// register indexes
	localparam logic [3:0] REG_CTRL = 4'h0; // mode bits
	localparam logic [3:0] REG_LBITS = 4'h1; // latch bit count
	localparam logic [3:0] REG_THR = 4'h2; // level threshold property
	localparam logic [3:0] REG_OFF = 4'h3; // level offset property
	localparam logic [3:0] REG_JTHR = 4'h4; // jump threshold property
	localparam logic [3:0] REG_JWIN = 4'h5; // jump window in levels
	localparam logic [3:0] REG_QRY = 4'h6; // write: start query
	localparam logic [3:0] REG_FRR = 4'h7; // fast read register
	localparam logic [3:0] REG_QCUR = 4'h8; // query: current level
	localparam logic [3:0] REG_QLAT = 4'h9; // query: latched level
	localparam logic [3:0] REG_STAT = 4'ha; // status flags
	// control field positions
	localparam int CTL_MODE = 0; // [1:0] latch event
	localparam int CTL_AVG = 2; // four-bit averaging
	localparam int CTL_JUP = 3; // jump up enable
	localparam int CTL_JDN = 4; // jump down enable
	localparam int CTL_JRST = 5; // restart rx on jump
	// status field positions
	localparam int ST_LATV = 0; // latched value captured
	localparam int ST_CCA = 1; // current above threshold
	localparam int ST_CCAL = 2; // latched above threshold
	localparam int ST_JMP = 3; // jump seen
	localparam int ST_QDONE = 4; // query answer ready
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] LBITS_RST = 8'h04;
	localparam logic [7:0] THR_RST = 8'hff;
	localparam logic [7:0] OFF_RST = 8'h40;
	localparam logic [7:0] JTHR_RST = 8'h0c;
	localparam logic [2:0] JWIN_RST = 3'h3;
	// latch timing in bit times
	localparam logic [7:0] MIN_BITS = 8'h04;
	localparam logic [7:0] MIN_BITS_AVG = 8'h07;
	// query turnaround
	localparam int QRY_NS = 33000; // 33 us
	localparam int CLK_NS = 10;
	localparam int QRY_CYC = QRY_NS / CLK_NS;
	localparam logic [11:0] QRY_LAST = 12'(QRY_CYC - 1);
	// latch event selection
	typedef enum logic [1:0] {
		LM_PREAMBLE = 2'b00,
		LM_SYNC = 2'b01,
		LM_BITS = 2'b10,
		LM_NONE = 2'b11
	} rsm_mode_e;
	// register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rsm_bus_s;
	// receive chain events, same clock domain
	typedef struct packed {
		logic rx_start; // receive mode entered
		logic preamble; // preamble detected
		logic sync; // sync word detected
	} rsm_evt_s;
endpackage : rsm_pkg
`default_nettype wire
